// ---- logic/arp_datapath.sv ----
/*
 * ALU datapath: three accumulators, a pointer-mapped RAM word, a byte store
 * reached by the same pointer, four condition flags and the result slots.
 * Assumes the instruction sequencer waits for cmd_done before its next
 * command, and the measurement front end holds a result until res_ready.
 */
// What this block does
// - The data RAM has its own 256-word address path.
// - Each RAM word is 24 bits, like the accumulators.
// - The pointed RAM word serves as a fourth operand register.
// - Changing the pointer never alters any RAM contents.
// - Only pointer load and increment opcodes change the pointer.
// - Byte get and put use the pointer on the 128-byte store.
// - All other opcodes apply the pointer to the data RAM.
// - Three 24-bit accumulators X, Y and Z exist.
// - Transfers and arithmetic accept all four accumulators.
// - Four flags; not-equal and sign refresh on every accumulator write.
// - Carry and overflow also update on add, subtract and right shift.
// - Jumps can test each of the four flags alone.
// - Carry takes the add or subtract carry, or the bit shifted out.
// - Not-equal flag goes to zero when a nonzero result is written.
// - Sign flag is set when the written result's MSB is one.
// - Overflow flags a signed add or subtract out of range.
// - Slots 16 to 19 hold the four bridge ratios.
// - Slot 20 holds the averaged bridge result.
// - Slot 22 holds the measurement status word.
// - Slot 23 holds raw port time; slot 21 the temperature ratio.
// - Slots 26 to 28 hold key falling, rising and pressed state.
// - Slot 29 pin state, slot 30 timer, slot 31 span result.
// - In stand-alone mode, addresses 240 to 255 show slots 16 to 31.
// - The byte store moves one 8-bit byte per get or put.
`timescale 1ns/1ps
`default_nettype none
module arp_datapath
   import arp_pkg::*;
(
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Mode.
   input wire logic stand_alone,
   // Command from the instruction sequencer.
   input wire logic cmd_valid,
   input wire arp_cmd_t cmd,
   output logic cmd_ready,
   output logic cmd_done,
   // Branch condition test.
   input wire arp_cond_t cond_sel,
   output logic cond_true,
   // Results from the measurement front end.
   input wire logic res_valid,
   input wire arp_result_t res,
   output logic res_ready,
   // State visible to the sequencer.
   output arp_flags_t flags,
   output logic [7:0] ram_ptr
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   arp_state_t state_reg;
   arp_state_t state_next;
   arp_cmd_t cmd_reg;
   arp_flags_t flags_reg;
   arp_flags_t flags_alu;
   logic [7:0] ptr_reg;
   logic [7:0] ptr_next;
   logic [23:0] acc_q [0:2];
   logic [23:0] ram_rdata;
   logic [23:0] ram_wdata;
   logic [7:0] ram_addr;
   logic [7:0] phys_ptr;
   logic ram_we;
   logic [7:0] eep_rdata;
   logic eep_we;
   logic [23:0] dst_val;
   logic [23:0] src_val;
   logic [23:0] dst_res;
   logic [23:0] src_res;
   logic dst_wr;
   logic src_wr;
   logic in_exec;
   logic exec_ce;
   logic cmd_take;
   logic res_take;
   logic mirror_hit;
   logic ptr_op;
   logic ram_dst_wr;
   logic ram_src_wr;

   ////////////////////////////////////////////////////////////////////////////
   // Handshakes: a result write takes the RAM port ahead of a new command.
   assign in_exec = (state_reg == ST_EXEC);
   assign exec_ce = in_exec && ce;
   assign res_ready = (state_reg == ST_IDLE);
   assign res_take = res_valid && res_ready;
   assign cmd_ready = (state_reg == ST_IDLE) && !res_valid;
   assign cmd_take = cmd_valid && cmd_ready;
   assign cmd_done = exec_ce;

   // Sequencer: idle, fetch the mapped words, execute and write back.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_take) begin
               state_next = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_next = ST_EXEC;
         end
         ST_EXEC: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State and command registers.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         cmd_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
         if (cmd_take) begin
            cmd_reg <= cmd;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointer and its mapping onto the physical RAM.
   assign ptr_op = (cmd_reg.op == OP_LOAD_PTR) || (cmd_reg.op == OP_INC_PTR);
   assign mirror_hit = stand_alone && (ptr_reg >= MIRROR_BASE);
   assign phys_ptr = mirror_hit ? (ptr_reg - MIRROR_SHIFT) : ptr_reg;

   assign ptr_next = (cmd_reg.op == OP_LOAD_PTR) ? cmd_reg.imm[7:0] : (ptr_reg + 8'h01);

   // The pointer register changes only while its own opcode executes.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_reg <= PTR_RESET;
      end else if (exec_ce && ptr_op) begin
         ptr_reg <= ptr_next;
      end
   end

   assign ram_ptr = ptr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection; the mapped RAM word acts as a fourth accumulator.
   // mapped word as operand.
   assign dst_val = (cmd_reg.dst == ACC_RAM) ? ram_rdata : acc_q[cmd_reg.dst[1:0]];
   assign src_val = (cmd_reg.src == ACC_RAM) ? ram_rdata : acc_q[cmd_reg.src[1:0]];

   arp_alu u_alu (
      .op(cmd_reg.op),
      .a(dst_val),
      .b(src_val),
      .imm(cmd_reg.imm),
      .eep_byte(eep_rdata),
      .flags_in(flags_reg),
      .dst_res(dst_res),
      .src_res(src_res),
      .dst_wr(dst_wr),
      .src_wr(src_wr),
      .flags_out(flags_alu)
   );

   for (genvar gi = 0; gi < 3; gi++) begin : g_acc
      logic [23:0] acc_reg;
      logic [23:0] acc_next;
      logic [1:0] my_sel;
      assign my_sel = 2'(gi);
      assign acc_next = (dst_wr && (cmd_reg.dst == my_sel)) ? dst_res :
                        (src_wr && (cmd_reg.src == my_sel)) ? src_res : acc_reg;
      // Each accumulator loads only while a command executes.
      always_ff @(posedge core_clk or negedge rst_b) begin
         if (!rst_b) begin
            acc_reg <= ACC_RESET;
         end else if (exec_ce) begin
            acc_reg <= acc_next;
         end
      end
      assign acc_q[gi] = acc_reg;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_reg <= FLAGS_RESET;
      end else if (exec_ce) begin
         flags_reg <= flags_alu;
      end
   end

   assign flags = flags_reg;

   assign cond_true = (cond_sel == COND_CARRY) ? flags_reg.carry :
                      (cond_sel == COND_NOT_EQUAL) ? flags_reg.not_equal :
                      (cond_sel == COND_SIGN) ? flags_reg.sign : flags_reg.overflow;

   ////////////////////////////////////////////////////////////////////////////
   // Data RAM port: a result slot when a result is taken, the mapped word otherwise.
   assign ram_dst_wr = dst_wr && (cmd_reg.dst == ACC_RAM);
   assign ram_src_wr = src_wr && (cmd_reg.src == ACC_RAM);
   assign ram_we = res_take || (in_exec && (ram_dst_wr || ram_src_wr));
   assign ram_addr = res_take ? (RESULT_BASE + {4'h0, res.slot}) : phys_ptr;
   assign ram_wdata = res_take ? res.data : (ram_dst_wr ? dst_res : src_res);

   arp_mem #(
      .W(ACC_W),
      .AW(RAM_AW)
   ) u_ram (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   assign eep_we = in_exec && (cmd_reg.op == OP_PUT_BYTE);

   arp_mem #(
      .W(EEP_W),
      .AW(EEP_AW)
   ) u_byte_store (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .we(eep_we),
      .addr(ptr_reg[6:0]),
      .wdata(src_val[7:0]),
      .rdata(eep_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the datapath.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   AST_PTR_OWN_OPS: assert property (
      (ptr_reg != $past(ptr_reg)) |-> $past(exec_ce && ptr_op))
      else $error("Pointer changed outside its own opcodes.");

   AST_PTR_WRAP: assert property (
      (exec_ce && (cmd_reg.op == OP_INC_PTR) && (ptr_reg == 8'hff)) |=> (ptr_reg == 8'h00))
      else $error("Pointer increment did not wrap to zero.");

   AST_PTR_NO_RAM_WRITE: assert property (
      (in_exec && ptr_op) |-> !ram_we)
      else $error("Pointer opcode wrote the RAM.");

   AST_BYTE_STORE_ONLY_PUT: assert property (
      eep_we |-> (in_exec && (cmd_reg.op == OP_PUT_BYTE) && !ram_we))
      else $error("Byte store written by the wrong opcode.");

   AST_FLAGS_HOLD: assert property (
      (flags_reg != $past(flags_reg)) |-> $past(exec_ce && dst_wr))
      else $error("Flags changed without an accumulator write.");

   AST_NE_SIGN: assert property (
      (exec_ce && dst_wr) |=> ((flags_reg.not_equal == ($past(dst_res) == 24'h000000)) &&
                               (flags_reg.sign == $past(dst_res[23]))))
      else $error("Not-equal or sign flag wrong after a write.");

   AST_ADD_CARRY: assert property (
      (exec_ce && (cmd_reg.op == OP_ADD)) |=>
         (flags_reg.carry == $past(({1'b0, dst_val} + {1'b0, src_val}) >> 24)))
      else $error("Carry does not match the addition.");

   AST_RESULT_SLOT: assert property (
      (res_take && ce) |-> (ram_we && (ram_addr == (8'h10 + {4'h0, res.slot}))))
      else $error("Result not written to its slot.");

   AST_MIRROR: assert property (
      (stand_alone && (ptr_reg >= 8'hf0) && !res_take) |-> (ram_addr == (ptr_reg - 8'he0)))
      else $error("Stand-alone window not mapped onto the result slots.");

   AST_CMD_FLOW: assert property (
      (cmd_take && ce) ##1 ce[*2] |-> ##1 (state_reg == ST_IDLE) && $past(cmd_done))
      else $error("Command did not complete in three cycles.");

   AST_COND_SELECT: assert property (
      cond_true == flags_reg[3 - cond_sel])
      else $error("Branch condition does not match the selected flag.");

   AST_SUB_BORROW: assert property (
      (exec_ce && (cmd_reg.op == OP_SUB)) |=>
         (flags_reg.carry == ($past(dst_val) < $past(src_val))))
      else $error("Carry does not match the subtraction borrow.");

   AST_RSHIFT_FLAGS: assert property (
      (exec_ce && (cmd_reg.op == OP_RIGHT_SHIFT)) |=>
         ((flags_reg.carry == $past(dst_val[0])) && !flags_reg.overflow))
      else $error("Right shift carry or overflow wrong.");

   AST_ADD_OVERFLOW: assert property (
      (exec_ce && (cmd_reg.op == OP_ADD)) |=>
         (flags_reg.overflow == $past(^(({dst_val[23], dst_val} + {src_val[23], src_val}) >> 23))))
      else $error("Overflow does not match the signed addition.");

   AST_GET_ONE_BYTE: assert property (
      (exec_ce && (cmd_reg.op == OP_GET_BYTE)) |-> (dst_wr && (dst_res[23:8] == 16'h0000)))
      else $error("Byte get moved more than one byte.");

   AST_SWAP_BOTH: assert property (
      (exec_ce && (cmd_reg.op == OP_SWAP)) |->
         (dst_wr && src_wr && (dst_res == src_val) && (src_res == dst_val)))
      else $error("Swap did not exchange both operands.");

   COV_SWAP_RAM: cover property (exec_ce && (cmd_reg.op == OP_SWAP) && (cmd_reg.src == ACC_RAM));
   COV_GET_BYTE: cover property (exec_ce && (cmd_reg.op == OP_GET_BYTE));
   COV_MIRROR_READ: cover property (exec_ce && mirror_hit && (cmd_reg.op == OP_MOVE));
   COV_ADD_OVERFLOW: cover property (exec_ce && (cmd_reg.op == OP_ADD) && flags_alu.overflow);
   COV_RESULT_WRITE: cover property (res_take && ce);

endmodule : arp_datapath
`default_nettype wire

// ---- logic/arp_pkg.sv ----
/*
 * Shared constants and types of the accumulator, RAM pointer and ALU datapath.
 * Assumes it is compiled before every module that imports it.
 */
`default_nettype none
package arp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and depths.
   localparam int ACC_W = 24;
   localparam int RAM_AW = 8;
   localparam int EEP_AW = 7;
   localparam int EEP_W = 8;
   localparam int PROD_W = 48;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [23:0] ACC_RESET = 24'h000000;
   localparam logic [23:0] MEM_RD_RESET = 24'h000000;

   ////////////////////////////////////////////////////////////////////////////
   // Fixed RAM slots for measurement results and status.
   localparam logic [7:0] ADDR_BRIDGE1_RATIO = 8'h10;
   localparam logic [7:0] ADDR_BRIDGE2_RATIO = 8'h11;
   localparam logic [7:0] ADDR_BRIDGE3_RATIO = 8'h12;
   localparam logic [7:0] ADDR_BRIDGE4_RATIO = 8'h13;
   localparam logic [7:0] ADDR_BRIDGE_AVERAGE = 8'h14;
   localparam logic [7:0] ADDR_TEMPERATURE_RATIO = 8'h15;
   localparam logic [7:0] ADDR_MEASUREMENT_STATUS = 8'h16;
   localparam logic [7:0] ADDR_RAW_PORT_TIME = 8'h17;
   localparam logic [7:0] ADDR_CONVERTER_RESOLUTION = 8'h18;
   localparam logic [7:0] ADDR_SUPPLY_LEVEL = 8'h19;
   localparam logic [7:0] ADDR_KEY_FALLING_EDGES = 8'h1a;
   localparam logic [7:0] ADDR_KEY_RISING_EDGES = 8'h1b;
   localparam logic [7:0] ADDR_KEY_PRESSED_STATE = 8'h1c;
   localparam logic [7:0] ADDR_PIN_EDGE_STATE = 8'h1d;
   localparam logic [7:0] ADDR_TIMER_STATE = 8'h1e;
   localparam logic [7:0] ADDR_SPAN_RESISTOR_RESULT = 8'h1f;
   localparam logic [7:0] RESULT_BASE = ADDR_BRIDGE1_RATIO;
   // Stand-alone mirror window and the distance down to the result slots.
   localparam logic [7:0] MIRROR_BASE = 8'hf0;
   localparam logic [7:0] MIRROR_SHIFT = 8'he0;

   ////////////////////////////////////////////////////////////////////////////
   // Opcodes, operand selects, flag selects and sequencer states.
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_LOAD_PTR = 4'h1,
      OP_INC_PTR = 4'h2,
      OP_MOVE = 4'h3,
      OP_SWAP = 4'h4,
      OP_ADD = 4'h5,
      OP_SUB = 4'h6,
      OP_LEFT_SHIFT = 4'h7,
      OP_RIGHT_SHIFT = 4'h8,
      OP_RIGHT_ROTATE = 4'h9,
      OP_WIDE_MULTIPLY = 4'ha,
      OP_CLEAR = 4'hb,
      OP_LOAD_IMM = 4'hc,
      OP_GET_BYTE = 4'hd,
      OP_PUT_BYTE = 4'he
   } arp_op_t;

   typedef enum logic [1:0] {
      ACC_X = 2'b00,
      ACC_Y = 2'b01,
      ACC_Z = 2'b10,
      ACC_RAM = 2'b11
   } arp_acc_t;

   typedef enum logic [1:0] {
      COND_CARRY = 2'b00,
      COND_NOT_EQUAL = 2'b01,
      COND_SIGN = 2'b10,
      COND_OVERFLOW = 2'b11
   } arp_cond_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC = 2'b10
   } arp_state_t;

   typedef struct packed {
      logic carry;
      logic not_equal;
      logic sign;
      logic overflow;
   } arp_flags_t;

   localparam arp_flags_t FLAGS_RESET = 4'h0;

   typedef struct packed {
      arp_op_t op;
      arp_acc_t dst;
      arp_acc_t src;
      logic [23:0] imm;
   } arp_cmd_t;

   typedef struct packed {
      logic [3:0] slot;
      logic [23:0] data;
   } arp_result_t;

endpackage : arp_pkg
`default_nettype wire

// ---- logic/arp_mem.sv ----
/*
 * Single-port memory with a registered read port.
 * Assumes one clock and a clock enable that freezes writes and reads.
 */
`timescale 1ns/1ps
`default_nettype none
module arp_mem
   import arp_pkg::*;
#(
   parameter int W = ACC_W,
   parameter int AW = RAM_AW
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Access port.
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] rdata
);

   logic [W-1:0] mem_array [0:(1<<AW)-1];
   logic [W-1:0] rdata_reg;

   // The array holds no reset; a write never disturbs another word.
   always_ff @(posedge core_clk) begin
      if (ce && we) begin
         mem_array[addr] <= wdata;
      end
   end

   // Read data comes out of a register one cycle after the address.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= MEM_RD_RESET[W-1:0];
      end else if (ce && !we) begin
         rdata_reg <= mem_array[addr];
      end
   end

   assign rdata = rdata_reg;

endmodule : arp_mem
`default_nettype wire

// ---- logic/arp_alu.sv ----
/*
 * Combinational arithmetic unit: results, write strobes and next flags.
 * Assumes the caller registers everything it produces.
 */
`timescale 1ns/1ps
`default_nettype none
module arp_alu
   import arp_pkg::*;
(
   // Operation and operands.
   input wire arp_op_t op,
   input wire logic [23:0] a,
   input wire logic [23:0] b,
   input wire logic [23:0] imm,
   input wire logic [7:0] eep_byte,
   input wire arp_flags_t flags_in,
   // Results.
   output logic [23:0] dst_res,
   output logic [23:0] src_res,
   output logic dst_wr,
   output logic src_wr,
   output arp_flags_t flags_out
);

   logic [24:0] sum_w;
   logic [24:0] diff_w;
   logic [47:0] prod_w;

   // Wide intermediate results keep the carry and borrow bits.
   assign sum_w = {1'b0, a} + {1'b0, b};
   assign diff_w = {1'b0, a} - {1'b0, b};
   assign prod_w = a * b;

   // Result selection and flag update per opcode.
   always_comb begin
      dst_res = a;
      src_res = b;
      dst_wr = 1'b0;
      src_wr = 1'b0;
      flags_out = flags_in;
      case (op)
         OP_MOVE: begin
            dst_res = b;
            dst_wr = 1'b1;
         end
         OP_SWAP: begin
            dst_res = b;
            src_res = a;
            dst_wr = 1'b1;
            src_wr = 1'b1;
         end
         OP_ADD: begin
            dst_res = sum_w[23:0];
            dst_wr = 1'b1;
            flags_out.carry = sum_w[24];
            flags_out.overflow = (a[23] == b[23]) && (sum_w[23] != a[23]);
         end
         OP_SUB: begin
            dst_res = diff_w[23:0];
            dst_wr = 1'b1;
            flags_out.carry = diff_w[24];
            flags_out.overflow = (a[23] != b[23]) && (diff_w[23] != a[23]);
         end
         OP_LEFT_SHIFT: begin
            dst_res = {a[22:0], 1'b0};
            dst_wr = 1'b1;
            flags_out.carry = a[23];
         end
         OP_RIGHT_SHIFT: begin
            dst_res = {a[23], a[23:1]};
            dst_wr = 1'b1;
            flags_out.carry = a[0];
            flags_out.overflow = 1'b0;
         end
         OP_RIGHT_ROTATE: begin
            dst_res = {a[0], a[23:1]};
            dst_wr = 1'b1;
            flags_out.carry = a[0];
         end
         OP_WIDE_MULTIPLY: begin
            dst_res = prod_w[23:0];
            dst_wr = 1'b1;
         end
         OP_CLEAR: begin
            dst_res = ACC_RESET;
            dst_wr = 1'b1;
         end
         OP_LOAD_IMM: begin
            dst_res = imm;
            dst_wr = 1'b1;
         end
         OP_GET_BYTE: begin
            dst_res = {16'h0000, eep_byte};
            dst_wr = 1'b1;
         end
         default: begin
            dst_wr = 1'b0;
         end
      endcase
      if (dst_wr) begin
         flags_out.not_equal = (dst_res == ACC_RESET);
         flags_out.sign = dst_res[23];
      end
   end

endmodule : arp_alu
`default_nettype wire

// ---- dv/arp_seq_model.sv ----
/*
 * Behavioural instruction sequencer that issues one command at a time.
 * Assumes the datapath answers with cmd_ready and cmd_done on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module arp_seq_model
   import arp_pkg::*;
(
   // Clock.
   input wire logic core_clk,
   // Command port.
   output logic cmd_valid,
   output arp_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic cmd_done
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle command lines at time zero.
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // Holds a command until it is taken, then waits for its completion.
   task automatic run(input arp_cmd_t c, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b1;
      cmd = c;
      for (n = 0; n < 20; n++) begin
         @(negedge core_clk);
         if (cmd_ready === 1'b1) break;
      end
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
      cmd = ~c; // Released lines show no stale command.
      for (n = 0; n < 10; n++) begin
         @(negedge core_clk);
         if (cmd_done === 1'b1) begin
            ok = 1'b1;
            break;
         end
      end
      @(posedge core_clk);
      #1;
   endtask : run
endmodule : arp_seq_model
`default_nettype wire

// ---- dv/testbench.sv ----
/*
 * Self-checking bench of the datapath, judged through flags and pointer.
 * Assumes the sequencer model drives the command port.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import arp_pkg::*;
   logic core_clk, rst_b, ce, stand_alone, cmd_valid, cmd_ready, cmd_done;
   logic cond_true, res_valid, res_ready;
   logic [7:0] ram_ptr;
   arp_cmd_t cmd;
   arp_cond_t cond_sel;
   arp_result_t res;
   arp_flags_t flags;
   int n_errors = 0;
   int n_checks = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Design and sequencer model.
   arp_datapath i_arp_datapath (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .stand_alone(stand_alone),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cond_sel(cond_sel),
      .cond_true(cond_true), .res_valid(res_valid), .res(res), .res_ready(res_ready), .flags(flags),
      .ram_ptr(ram_ptr));
   arp_seq_model i_arp_seq_model (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .cmd_done(cmd_done));

   // Clock of 10 ns.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // Compares a value and counts the outcome.
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Compares the flag register {carry,not_equal,sign,overflow}.
   task automatic fl(input logic [3:0] exp);
      chk({20'h0, flags}, {20'h0, exp});
   endtask : fl

   // Runs one command through the sequencer model.
   task automatic op(input arp_op_t o, input arp_acc_t d, input arp_acc_t s, input logic [23:0] imm);
      logic ok;
      i_arp_seq_model.run('{op: o, dst: d, src: s, imm: imm}, ok);
      if (ok !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: command not completed", $time);
         final_report();
      end
   endtask : op

   // Writes one result slot from the front end side.
   task automatic put_res(input logic [3:0] s, input logic [23:0] d);
      int n;
      @(posedge core_clk);
      #1;
      res_valid = 1'b1;
      res = '{slot: s, data: d};
      for (n = 0; n < 10; n++) begin
         @(negedge core_clk);
         if (res_ready === 1'b1) break;
      end
      if (n == 10) begin
         n_errors++;
         $display("mismatch at %0t: result not taken", $time);
         final_report();
      end
      @(posedge core_clk);
      #1;
      res_valid = 1'b0;
      res = ~res;
   endtask : put_res

   // Values while reset is still held.
   task automatic t_reset();
      fl(4'h0);
      chk({16'h0, ram_ptr}, 24'h0);
      chk({23'h0, res_ready}, 24'h1);
      chk({23'h0, cmd_done}, 24'h0);
   endtask : t_reset

   // Pointer wrap; flags and pointer untouched by unrelated operations.
   task automatic t_pointer();
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'h0000ff);
      op(OP_LOAD_IMM, ACC_X, ACC_X, 24'h800000);
      chk({16'h0, ram_ptr}, 24'hff);
      op(OP_INC_PTR, ACC_X, ACC_X, 24'h0);
      chk({16'h0, ram_ptr}, 24'h00);
      fl(4'b0010);
   endtask : t_pointer

   // Pointed RAM word as operand, kept across pointer changes.
   task automatic t_ram_word();
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'h3);
      op(OP_LOAD_IMM, ACC_RAM, ACC_X, 24'h800001);
      fl(4'b0010);
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'h4);
      op(OP_LOAD_IMM, ACC_RAM, ACC_X, 24'h0);
      fl(4'b0100);
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'h3);
      op(OP_MOVE, ACC_X, ACC_RAM, 24'h0);
      fl(4'b0010);
   endtask : t_ram_word

   // Byte store through the pointer, apart from the RAM word.
   task automatic t_byte();
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'h4);
      op(OP_LOAD_IMM, ACC_X, ACC_X, 24'hffffff);
      op(OP_PUT_BYTE, ACC_X, ACC_X, 24'h0);
      fl(4'b0010);
      op(OP_GET_BYTE, ACC_Y, ACC_Y, 24'h0);
      fl(4'b0000);
      op(OP_MOVE, ACC_Z, ACC_RAM, 24'h0);
      fl(4'b0100);
   endtask : t_byte

   // Add, subtract and shift flags, and each flag as branch condition.
   task automatic t_arith();
      int i;
      logic [3:0] exp_fl = 4'b0011;
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'h5);
      op(OP_LOAD_IMM, ACC_RAM, ACC_X, 24'h7fffff);
      op(OP_LOAD_IMM, ACC_Y, ACC_X, 24'h000001);
      op(OP_ADD, ACC_RAM, ACC_Y, 24'h0);
      fl(4'b0011);
      for (i = 0; i < 4; i++) begin
         @(posedge core_clk);
         #1;
         cond_sel = arp_cond_t'(i);
         @(negedge core_clk);
         chk({23'h0, cond_true}, {23'h0, exp_fl[3-i]});
      end
      op(OP_LOAD_IMM, ACC_X, ACC_X, 24'hffffff);
      op(OP_ADD, ACC_X, ACC_Y, 24'h0);
      fl(4'b1100);
      op(OP_SUB, ACC_X, ACC_Y, 24'h0);
      fl(4'b1010);
      op(OP_LOAD_IMM, ACC_Z, ACC_X, 24'h000001);
      op(OP_RIGHT_SHIFT, ACC_Z, ACC_Z, 24'h0);
      fl(4'b1100);
   endtask : t_arith

   // Result slots, their stand-alone mirror and separate high words.
   task automatic t_slots();
      int s;
      for (s = 0; s < 16; s++) put_res(4'(s), s[0] ? 24'h800000 : 24'h0);
      stand_alone = 1'b1;
      for (s = 0; s < 16; s++) begin
         op(OP_LOAD_PTR, ACC_X, ACC_X, 24'(8'hf0 + s));
         op(OP_MOVE, ACC_X, ACC_RAM, 24'h0);
         fl(s[0] ? 4'b1010 : 4'b1100);
         op(OP_LOAD_PTR, ACC_X, ACC_X, 24'(8'h10 + s));
         op(OP_MOVE, ACC_Y, ACC_RAM, 24'h0);
         fl(s[0] ? 4'b1010 : 4'b1100);
      end
      stand_alone = 1'b0;
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'hf1);
      op(OP_LOAD_IMM, ACC_RAM, ACC_X, 24'h0);
      op(OP_LOAD_PTR, ACC_X, ACC_X, 24'h11);
      op(OP_MOVE, ACC_X, ACC_RAM, 24'h0);
      fl(4'b1010);
   endtask : t_slots

   // Swap with the mapped word, left shift, rotate, multiply and clear.
   task automatic t_ops();
      op(OP_LOAD_IMM, ACC_Z, ACC_X, 24'h000003);
      op(OP_SWAP, ACC_Z, ACC_RAM, 24'h0);
      fl(4'b1010);
      op(OP_MOVE, ACC_X, ACC_RAM, 24'h0);
      fl(4'b1000);
      op(OP_LEFT_SHIFT, ACC_X, ACC_X, 24'h0);
      fl(4'b0000);
      op(OP_RIGHT_ROTATE, ACC_X, ACC_X, 24'h0);
      op(OP_RIGHT_ROTATE, ACC_X, ACC_X, 24'h0);
      fl(4'b1010);
      op(OP_WIDE_MULTIPLY, ACC_X, ACC_X, 24'h0);
      fl(4'b1000);
      op(OP_CLEAR, ACC_RAM, ACC_X, 24'h0);
      fl(4'b1100);
      op(OP_MOVE, ACC_Y, ACC_RAM, 24'h0);
      fl(4'b1100);
   endtask : t_ops

   // Main sequence.
   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      stand_alone = 1'b0;
      cond_sel = COND_CARRY;
      res_valid = 1'b0;
      res = '0;
      repeat (5) @(posedge core_clk);
      t_reset();
      #1;
      rst_b = 1'b1;
      t_pointer();
      t_ram_word();
      t_byte();
      t_arith();
      t_slots();
      t_ops();
      final_report();
   end
endmodule : testbench
`default_nettype wire
